// >>> smrc_pkg.sv
// Constants, register map and carrier types for the synthesizer and
// modem rate configuration group.
// Assumes one device clock taken from the crystal oscillator.
//
// Notes on behaviour
// RL1 - Offset trim is two's complement and is added to the carrier word.
// RL2 - One offset step is crystal over 2^14, four carrier word steps.
// RL3 - Correction strobe or compensation adds the error estimate into the offset.
// RL4 - Carrier word bits 23:22 are read only and always read zero.
// RL5 - Carrier is crystal over 2^16 times the 24-bit word of three bytes.
// RL6 - Filter decimation is 8 times (4 plus mantissa) times 2^exponent.
// RL7 - Host never programs filter exponent and mantissa both to zero.
// RL8 - Symbol rate is a float with 8-bit mantissa, hidden one, 4-bit exponent.
// RL9 - Rate word is (256 plus mantissa) times 2^exponent, over 2^28 of crystal.
// RL10 - Rate exponent sits in bits 3:0; mantissa fills the next register.
// RL11 - Slot index times channel spacing is added to the base carrier.
// RL12 - Host writes to carrier high bits 7:6 are dropped; bits 5:0 stored.
package smrc_pkg;

  // ==========================================================================
  // Register map
  localparam int ADDR_W = 6;
  localparam logic [5:0] ADDR_OFFSET_TRIM = 6'h0C;
  localparam logic [5:0] ADDR_CARRIER_HIGH = 6'h0D;
  localparam logic [5:0] ADDR_CARRIER_MID = 6'h0E;
  localparam logic [5:0] ADDR_CARRIER_LOW = 6'h0F;
  localparam logic [5:0] ADDR_FILTER_RATE_EXP = 6'h10;
  localparam logic [5:0] ADDR_RATE_MANTISSA = 6'h11;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_OFFSET_TRIM = 8'h00;
  localparam logic [7:0] RST_CARRIER_HIGH = 8'h1E;
  localparam logic [7:0] RST_CARRIER_MID = 8'hC4;
  localparam logic [7:0] RST_CARRIER_LOW = 8'hEC;
  localparam logic [7:0] RST_FILTER_RATE_EXP = 8'h8C;
  localparam logic [7:0] RST_RATE_MANTISSA = 8'h22;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ==========================================================================
  // Field layout and arithmetic constants
  localparam int CARRIER_STORED_W = 22;
  localparam logic [1:0] CARRIER_TOP_ZERO = 2'h0;
  localparam int SYNTH_W = 26;
  localparam int OFFSET_SHIFT = 2;
  localparam logic [8:0] BW_MANT_BASE = 9'h004;
  localparam int BW_SCALE_SHIFT = 3;
  localparam logic [23:0] RATE_HIDDEN_ONE = 24'h000100;

  typedef struct packed {
    logic [7:0] frequency_offset;
    logic [21:0] carrier_word;
    logic [1:0] filter_bw_exponent;
    logic [1:0] filter_bw_mantissa;
    logic [3:0] symbol_rate_exponent;
    logic [7:0] symbol_rate_mantissa;
  } smrc_cfg_type;

  typedef struct packed {
    logic [25:0] synth_word;
    logic [8:0] decim_ratio;
    logic [23:0] rate_word;
  } smrc_derived_type;

  typedef struct packed {
    smrc_cfg_type cfg;
    logic [7:0] rd_data;
    smrc_derived_type derived;
  } smrc_state_type;

endpackage : smrc_pkg

// >>> smrc_derive.sv
// Combinational derivation of synthesizer, filter and rate control values.
// Assumes the caller registers the results.
`timescale 1ns/1ps

module smrc_derive
  import smrc_pkg::*;
(
  input wire smrc_cfg_type cfg, // Stored configuration fields
  input wire logic [7:0] rf_slot_index, // Unsigned channel index
  input wire logic [7:0] slot_spacing, // Channel spacing in carrier steps
  output smrc_derived_type derived // Derived control values
);

  logic [25:0] base_w;
  logic [25:0] slot_w;
  logic [25:0] offset_w;

  // ==========================================================================
  // Synthesizer word
  // The offset is four times coarser than a carrier step, so it is shifted
  // up rather than scaled by a multiplier.
  always_comb begin
    base_w = SYNTH_W'({CARRIER_TOP_ZERO, cfg.carrier_word}); // see RL5
    slot_w = SYNTH_W'(rf_slot_index * slot_spacing); // see RL11
    offset_w = SYNTH_W'({{18{cfg.frequency_offset[7]}},
      cfg.frequency_offset} << OFFSET_SHIFT); // see RL1 see RL2
    derived.synth_word = SYNTH_W'(base_w + slot_w + offset_w); // see RL1
    derived.decim_ratio = 9'((BW_MANT_BASE + 9'(cfg.filter_bw_mantissa))
      << (BW_SCALE_SHIFT + int'(cfg.filter_bw_exponent))); // see RL6
    derived.rate_word = 24'((RATE_HIDDEN_ONE + 24'(cfg.symbol_rate_mantissa))
      << cfg.symbol_rate_exponent); // see RL8 see RL9
  end

endmodule : smrc_derive

// >>> smrc_regs.sv
// Register group for carrier word, offset trim, filter bandwidth and rate.
// Assumes the serial port logic delivers decoded register accesses on the
// device clock, and correction events come from logic on the same clock.
`timescale 1ns/1ps

module smrc_regs
  import smrc_pkg::*;
(
  input wire logic ref_clk, // Device clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [5:0] reg_addr, // Register address
  input wire logic reg_wr, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, valid cycle after reg_rd
  input wire logic apply_correction_strobe, // Correction strobe command
  input wire logic auto_frequency_compensation, // Compensation event
  input wire logic [7:0] frequency_error_estimate, // Signed error estimate
  input wire logic [7:0] rf_slot_index, // Channel index
  input wire logic [7:0] slot_spacing, // Channel spacing in carrier steps
  output logic [25:0] synth_word, // Word driving the synthesizer
  output logic [8:0] decim_ratio, // Channel filter decimation ratio
  output logic [23:0] rate_word // Symbol rate word
);

  smrc_state_type st_q;
  smrc_state_type st_d;
  smrc_derived_type derived_c;

  // ==========================================================================
  // Register select
  // One decoded select serves both the write and the read path.
  typedef enum {
    SEL_NONE,
    SEL_TRIM,
    SEL_HIGH,
    SEL_MID,
    SEL_LOW,
    SEL_FILT,
    SEL_MANT
  } smrc_sel_type;

  smrc_sel_type acc_sel;

  smrc_derive u_derive (
    .cfg(st_q.cfg),
    .rf_slot_index(rf_slot_index),
    .slot_spacing(slot_spacing),
    .derived(derived_c)
  );

  // ==========================================================================
  // Address decode
  // Unmapped addresses decode to no register, so writes to them are lost
  // and reads of them return the unmapped value.
  function automatic smrc_sel_type decode_addr(input logic [5:0] addr);
    smrc_sel_type sel;
    sel = SEL_NONE;
    if (addr == ADDR_OFFSET_TRIM) begin
      sel = SEL_TRIM;
    end else if (addr == ADDR_CARRIER_HIGH) begin
      sel = SEL_HIGH;
    end else if (addr == ADDR_CARRIER_MID) begin
      sel = SEL_MID;
    end else if (addr == ADDR_CARRIER_LOW) begin
      sel = SEL_LOW;
    end else if (addr == ADDR_FILTER_RATE_EXP) begin
      sel = SEL_FILT;
    end else if (addr == ADDR_RATE_MANTISSA) begin
      sel = SEL_MANT;
    end else begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction : decode_addr

  // ==========================================================================
  // Register write
  // Only the six stored carrier bits are taken from the high byte; the two
  // top bits of the word are wired to zero and cannot be set by the host.
  function automatic smrc_cfg_type write_reg(
    input smrc_cfg_type cfg,
    input smrc_sel_type sel,
    input logic [7:0] data
  );
    smrc_cfg_type nxt;
    nxt = cfg;
    case (sel)
      SEL_TRIM: begin
        nxt.frequency_offset = data;
      end
      SEL_HIGH: begin
        nxt.carrier_word[21:16] = data[5:0]; // see RL12 see RL4
      end
      SEL_MID: begin
        nxt.carrier_word[15:8] = data;
      end
      SEL_LOW: begin
        nxt.carrier_word[7:0] = data;
      end
      SEL_FILT: begin
        // Exponent and mantissa both zero is not guarded here. See RL7.
        nxt.filter_bw_exponent = data[7:6]; // see RL6
        nxt.filter_bw_mantissa = data[5:4]; // see RL6
        nxt.symbol_rate_exponent = data[3:0]; // see RL10
      end
      SEL_MANT: begin
        nxt.symbol_rate_mantissa = data; // see RL10
      end
      default: begin
        nxt = cfg;
      end
    endcase
    return nxt;
  endfunction : write_reg

  // ==========================================================================
  // Register read
  function automatic logic [7:0] read_reg(
    input smrc_cfg_type cfg,
    input smrc_sel_type sel
  );
    logic [7:0] val;
    val = READ_UNMAPPED;
    case (sel)
      SEL_TRIM: begin
        val = cfg.frequency_offset;
      end
      SEL_HIGH: begin
        val = {CARRIER_TOP_ZERO, cfg.carrier_word[21:16]}; // see RL4
      end
      SEL_MID: begin
        val = cfg.carrier_word[15:8];
      end
      SEL_LOW: begin
        val = cfg.carrier_word[7:0];
      end
      SEL_FILT: begin
        val = {cfg.filter_bw_exponent, cfg.filter_bw_mantissa,
          cfg.symbol_rate_exponent}; // see RL10
      end
      SEL_MANT: begin
        val = cfg.symbol_rate_mantissa; // see RL10
      end
      default: begin
        val = READ_UNMAPPED;
      end
    endcase
    return val;
  endfunction : read_reg

  // ==========================================================================
  // Offset correction
  // The sum wraps in eight bits; a large estimate can fold the trim over
  // from one end of its range to the other, which the user must avoid.
  function automatic logic [7:0] corrected_offset(
    input logic [7:0] offset,
    input logic [7:0] estimate
  );
    return 8'(offset + estimate); // see RL3
  endfunction : corrected_offset

  // ==========================================================================
  // Reset configuration
  function automatic smrc_cfg_type reset_cfg();
    smrc_cfg_type cfg;
    cfg.frequency_offset = RST_OFFSET_TRIM;
    cfg.carrier_word = {RST_CARRIER_HIGH[5:0], RST_CARRIER_MID,
      RST_CARRIER_LOW};
    cfg.filter_bw_exponent = RST_FILTER_RATE_EXP[7:6];
    cfg.filter_bw_mantissa = RST_FILTER_RATE_EXP[5:4];
    cfg.symbol_rate_exponent = RST_FILTER_RATE_EXP[3:0];
    cfg.symbol_rate_mantissa = RST_RATE_MANTISSA;
    return cfg;
  endfunction : reset_cfg

  // ==========================================================================
  // Next state
  // The derived values are registered once more, so they follow a change
  // of configuration two edges after the write that made it.
  always_comb begin
    st_d = st_q;
    acc_sel = decode_addr(reg_addr);
    st_d.derived = derived_c;
    if (reg_wr) begin
      st_d.cfg = write_reg(st_q.cfg, acc_sel, reg_wdata);
    end
    // A correction in the same cycle as a host write to the trim wins, so
    // the hardware update is never lost.
    if (apply_correction_strobe || auto_frequency_compensation) begin
      st_d.cfg.frequency_offset = corrected_offset(
        st_q.cfg.frequency_offset, frequency_error_estimate); // see RL3
    end
    // A read in the same cycle as a write returns the old value.
    if (reg_rd) begin
      st_d.rd_data = read_reg(st_q.cfg, acc_sel);
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q.cfg <= reset_cfg();
      st_q.rd_data <= READ_UNMAPPED;
      st_q.derived <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rd_data;
  assign synth_word = st_q.derived.synth_word;
  assign decim_ratio = st_q.derived.decim_ratio;
  assign rate_word = st_q.derived.rate_word;

endmodule : smrc_regs

// >>> smrc_chk.sv
// Port assertions for the carrier and rate configuration registers.
// Bound to smrc_regs from the bench file.
`timescale 1ns/1ps
module smrc_chk (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [5:0] reg_addr, // Address
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_wdata, // Data in
  input wire logic [7:0] reg_rdata, // Data out
  input wire logic apply_correction_strobe, // Strobe
  input wire logic auto_frequency_compensation, // Event
  input wire logic [8:0] decim_ratio, // Ratio
  input wire logic [23:0] rate_word // Rate
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_top; reg_rd && reg_addr == 6'h0D |=> !reg_rdata[7:6]; endproperty
  a_top: assert property (p_top) else $error("top bits set");
  property p_hi; reg_wr && reg_addr == 6'h0D ##1 reg_rd && reg_addr == 6'h0D
    |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 2); endproperty
  a_hi: assert property (p_hi) else $error("high byte lost");
  property p_trim; reg_wr && reg_addr == 6'h0C && !apply_correction_strobe
    && !auto_frequency_compensation ##1 reg_rd && reg_addr == 6'h0C
    |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_trim: assert property (p_trim) else $error("trim lost");
  property p_void; reg_rd && (reg_addr < 6'h0C || reg_addr > 6'h11)
    |=> reg_rdata == 8'h00; endproperty
  a_void: assert property (p_void) else $error("unmapped read");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_dec; decim_ratio[2:0] == 3'h0; endproperty
  a_dec: assert property (p_dec) else $error("ratio not x8");
  property p_top_val; rate_word <= 24'hFF8000 && decim_ratio <= 9'h1C0;
  endproperty
  a_top_val: assert property (p_top_val) else $error("over range");
  property p_min; rst_n && $past(rst_n) && $past(rst_n, 2)
    |-> rate_word >= 24'h000100 && decim_ratio >= 9'h020; endproperty
  a_min: assert property (p_min) else $error("below range");
endmodule : smrc_chk

// >>> smrc_host.sv
// Host model on the register port.
// Tasks are entered just after a rising edge or off the edge.
`timescale 1ns/1ps
module smrc_host (
  input wire logic ref_clk, // Clock
  output logic [5:0] reg_addr, // Address
  output logic reg_wr, // Write strobe
  output logic [7:0] reg_wdata, // Write data
  output logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata // Read data
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 16'h0000;
  // ========
  // Bus tasks
  // The zero filter pair is unsupported, so it is nudged before sending.
  task automatic wr(input logic [5:0] a, inout logic [7:0] d);
    if (a == 6'h10 && d[7:4] == 4'h0) d[6] = 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    // Read data stands until the next read strobe, so it is taken at the
    // following edge, where it has long settled.
    @(posedge ref_clk);
    q = reg_rdata;
  endtask : rd
endmodule : smrc_host

// >>> synth_and_modem_rate_config_tb.sv
// Self-checking bench for the carrier and rate configuration registers.
// Compiled after the package, the design, the host model and the checker.
`timescale 1ns/1ps
bind smrc_regs smrc_chk chk_u (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .apply_correction_strobe,
  .auto_frequency_compensation, .decim_ratio, .rate_word);
module synth_and_modem_rate_config_tb;
  logic ref_clk = 1'b0;
  logic rst_n, cs, ca, reg_wr, reg_rd;
  logic [5:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, est, slot, sp, q, d;
  logic [7:0] mdl [12:17];
  logic [25:0] synth_word;
  logic [8:0] decim_ratio;
  logic [23:0] rate_word;
  logic [15:0] lf = 16'h3315;
  int error_cnt = 0;
  int tests_run = 0;
  smrc_regs dut_u (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .apply_correction_strobe(cs), .auto_frequency_compensation(ca),
    .frequency_error_estimate(est), .rf_slot_index(slot), .slot_spacing(sp),
    .synth_word, .decim_ratio, .rate_word);
  smrc_host host_u (.ref_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata);
  initial forever #12.5 ref_clk = ~ref_clk;
  // ========
  // Model and checks
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  task automatic cmp(input string n, input logic [25:0] e, s);
    tests_run++;
    if (s !== e) $display("mismatch %s expected %h seen %h", n, e, s);
    if (s !== e) error_cnt++;
  endtask : cmp
  task automatic outs;
    cmp("synth", {4'h0, mdl[13][5:0], mdl[14], mdl[15]} + slot * sp
      + {{16{mdl[12][7]}}, mdl[12], 2'h0}, synth_word);
    cmp("decim", 26'((4 + mdl[16][5:4]) * 8) << mdl[16][7:6],
      26'(decim_ratio));
    cmp("rate", 26'(256 + mdl[17]) << mdl[16][3:0], 26'(rate_word));
  endtask : outs
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    repeat (9000) @(posedge ref_clk);
    error_cnt++;
    stop_test;
  end
  initial begin
    {rst_n, cs, ca, est, slot, sp} = 27'h0;
    mdl = '{8'h00, 8'h1E, 8'hC4, 8'hEC, 8'h8C, 8'h22};
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 11; i < 19; i++) begin
      host_u.rd(6'(i), q);
      cmp("reset", i > 11 && i < 18 ? mdl[i] : 8'h00, q);
    end
    outs;
    $display("test reset done");
    for (int i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      lf = nxt(lf);
      a = i < 6 ? 6'(12 + i) : 6'(12 + lf[10:8] % 6);
      d = lf[7:0];
      {cs, ca} <= i < 6 ? 2'h0 : lf[12:11];
      {est, slot, sp} <= {lf[15:8], lf[14:7], lf[13:6]};
      host_u.wr(a, d);
      if (a != 6'h0C || !(cs || ca)) mdl[a] = a == 6'h0D ? d & 8'h3F : d;
      if (cs || ca) mdl[12] = mdl[12] + est;
      {cs, ca} <= 2'h0;
      host_u.rd(a, q);
      cmp("reg", mdl[a], q);
      @(posedge ref_clk);
      #1 outs;
    end
    $display("test random done");
    stop_test;
  end
endmodule : synth_and_modem_rate_config_tb
